// >>> verilog/pzt_sram_port.v
// Behaviour
// - write data captured two cycles after command
// - read data out two cycles after command
// - reads and writes mix with no dead cycles
// - read_not_write picks operation on load only
// - each byte lane write gated by its enable
// - drive data only when enabled and output enabled
// - any inactive select on load deselects outputs
// - deselect takes effect after two-cycle pipeline drain
// - advance ignores address, selects, read_not_write
// - selected load takes new address and operation
// - chip selects sampled only on load cycles
// - order select high gives interleaved burst
// - order select low gives linear burst
// - order select is a static strap, default interleaved
// - clock hold high ignores the edge, except sleep sampling and output enable turning the bus off
// - sleep request holds deselected low power, data kept
// - asleep: inputs ignored, outputs high impedance
// - selected read load starts read burst
// - read load with output disabled is dummy read
// - read advance reads and drives next burst address
// - two-bit burst counter wraps every fourth cycle
// - sleep ignores and resamples inputs from second cycle
// - selected write load starts write burst
// - both lanes disabled is write abort
`include "pzt_sram_regs.vh"

module pzt_sram_port #(
   parameter ADDR_W = `PZT_ADDR_W,
   parameter DATA_W = `PZT_DATA_W,
   parameter LANE_W = `PZT_LANE_W,
   parameter LANES = `PZT_LANES,
   parameter DEPTH = 1 << `PZT_ADDR_W
) (
   // clock and reset
   input wire core_clk,
   input wire srst,
   // command
   input wire [ADDR_W-1:0] addr,
   input wire select_low_a,
   input wire select_high,
   input wire select_low_b,
   input wire advance_or_load,
   input wire read_not_write,
   input wire [LANES-1:0] byte_lane_write_n,
   input wire clock_hold_n,
   // static and clock-sampled controls
   input wire output_drive_enable_n,
   input wire burst_order_select,
   input wire sleep_request,
   // data pins
   input wire [DATA_W-1:0] dq_in,
   output reg [DATA_W-1:0] dq_out,
   output reg dq_oe,
   // status
   output reg sleep_active
);

   // burst state remembers the kind of the last load
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_READ = 3'h2;
   localparam [2:0] ST_WRITE = 3'h4;

   reg [DATA_W-1:0] mem [0:DEPTH-1];

   // burst tracking: upper bits fixed, two low bits counted
   reg [2:0] state_reg;
   reg [ADDR_W-3:0] base_reg;
   reg [1:0] start_reg;
   reg [1:0] cnt_reg;

   // two command stages line reads and writes up at two cycles
   reg [1:0] s1_op_reg;
   reg [ADDR_W-1:0] s1_addr_reg;
   reg [LANES-1:0] s1_be_reg;
   reg s1_drv_reg;
   reg [1:0] s2_op_reg;
   reg [ADDR_W-1:0] s2_addr_reg;
   reg [LANES-1:0] s2_be_reg;
   reg s2_drv_reg;

   // posted writes: entry storage and pointers
   reg [ADDR_W-1:0] buf_addr [0:`PZT_BUF_DEPTH-1];
   reg [LANES-1:0] buf_be [0:`PZT_BUF_DEPTH-1];
   reg [DATA_W-1:0] buf_data [0:`PZT_BUF_DEPTH-1];
   reg buf_rd_reg;
   reg buf_wr_reg;
   reg [1:0] buf_cnt_reg;

   wire is_load;
   wire selected;
   wire buf_full;
   wire stall;
   wire [1:0] cnt_next;
   wire [1:0] lo_next;
   wire push;
   wire pop;
   wire [LANES-1:0] be_in;

   reg [DATA_W-1:0] fwd_word;
   reg [DATA_W-1:0] wr_word;
   reg [1:0] fwd_idx;
   // each merge process owns its loop index, so no index has two drivers
   integer i;
   integer ln;
   integer wl;

   assign is_load = ~advance_or_load;
   assign selected = ~select_low_a & select_high & ~select_low_b;
   assign be_in = ~byte_lane_write_n;
   assign buf_full = (buf_cnt_reg == `PZT_BUF_DEPTH);
   // a full buffer stalls the pipeline exactly like a held clock
   assign stall = clock_hold_n | buf_full;
   assign cnt_next = cnt_reg + 2'h1;
   // strap is a plain level here; the pull-up lives in the pad ring
   assign lo_next = burst_order_select ? (start_reg ^ cnt_next)
                                       : (start_reg + cnt_next);
   assign push = ~stall & ~sleep_active & (s2_op_reg == `PZT_OP_WRITE) & (|s2_be_reg);
   // drain pauses while asleep so buffered words are retained
   // a held edge writes nothing, not even a posted word
   assign pop = (buf_cnt_reg != 2'h0) & ~sleep_active & ~clock_hold_n;

   // read word with younger posted writes merged in, oldest first
   always @* begin
      fwd_word = mem[s2_addr_reg];
      fwd_idx = 2'h0;
      for (i = 0; i < `PZT_BUF_DEPTH; i = i + 1) begin
         fwd_idx = {1'b0, buf_rd_reg} + i[1:0];
         if (i < buf_cnt_reg && buf_addr[fwd_idx[0]] == s2_addr_reg) begin
            for (ln = 0; ln < LANES; ln = ln + 1) begin
               if (buf_be[fwd_idx[0]][ln]) begin
                  fwd_word[ln*LANE_W +: LANE_W] = buf_data[fwd_idx[0]][ln*LANE_W +: LANE_W];
               end
            end
         end
      end
   end

   // byte-lane merge for the drained entry
   always @* begin
      wr_word = mem[buf_addr[buf_rd_reg]];
      for (wl = 0; wl < LANES; wl = wl + 1) begin
         if (buf_be[buf_rd_reg][wl]) begin
            wr_word[wl*LANE_W +: LANE_W] = buf_data[buf_rd_reg][wl*LANE_W +: LANE_W];
         end
      end
   end

   // array write port; no reset so contents survive srst and sleep
   always @(posedge core_clk) begin
      if (pop) begin
         mem[buf_addr[buf_rd_reg]] <= wr_word;
      end
   end

   // buffer entries; aborted writes never enter
   always @(posedge core_clk) begin
      if (push) begin
         buf_addr[buf_wr_reg] <= s2_addr_reg;
         buf_be[buf_wr_reg] <= s2_be_reg;
         buf_data[buf_wr_reg] <= dq_in;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         buf_rd_reg <= 1'b0;
         buf_wr_reg <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            buf_wr_reg <= ~buf_wr_reg;
         end
         if (pop) begin
            buf_rd_reg <= ~buf_rd_reg;
         end
         if (push & ~pop) begin
            buf_cnt_reg <= buf_cnt_reg + 2'h1;
         end else if (pop & ~push) begin
            buf_cnt_reg <= buf_cnt_reg - 2'h1;
         end
      end
   end

   // one flop: inputs ignored, and later resampled, from the second edge
   always @(posedge core_clk) begin
      if (srst) begin
         sleep_active <= 1'b0;
      end else begin
         sleep_active <= sleep_request;
      end
   end

   // burst control and first pipeline stage
   always @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         base_reg <= {(ADDR_W-2){1'b0}};
         start_reg <= 2'h0;
         cnt_reg <= 2'h0;
         s1_op_reg <= `PZT_OP_NONE;
         s1_addr_reg <= {ADDR_W{1'b0}};
         s1_be_reg <= {LANES{1'b0}};
         s1_drv_reg <= 1'b0;
      end else if (sleep_active) begin
         // in-flight work is dropped; the master must not rely on it
         state_reg <= ST_IDLE;
         s1_op_reg <= `PZT_OP_NONE;
         s1_drv_reg <= 1'b0;
      end else if (!stall) begin
         if (is_load) begin
            if (selected) begin
               state_reg <= read_not_write ? ST_READ : ST_WRITE;
               base_reg <= addr[ADDR_W-1:2];
               start_reg <= addr[1:0];
               cnt_reg <= 2'h0;
               s1_op_reg <= read_not_write ? `PZT_OP_READ : `PZT_OP_WRITE;
               s1_addr_reg <= addr;
               s1_be_reg <= read_not_write ? {LANES{1'b0}} : be_in;
               s1_drv_reg <= read_not_write & ~output_drive_enable_n;
            end else begin
               state_reg <= ST_IDLE;
               s1_op_reg <= `PZT_OP_NONE;
               s1_be_reg <= {LANES{1'b0}};
               s1_drv_reg <= 1'b0;
            end
         end else begin
            // address, selects and read_not_write are not looked at here
            case (state_reg)
               ST_READ: begin
                  cnt_reg <= cnt_next;
                  s1_op_reg <= `PZT_OP_READ;
                  s1_addr_reg <= {base_reg, lo_next};
                  s1_be_reg <= {LANES{1'b0}};
                  s1_drv_reg <= ~output_drive_enable_n;
               end
               ST_WRITE: begin
                  cnt_reg <= cnt_next;
                  s1_op_reg <= `PZT_OP_WRITE;
                  s1_addr_reg <= {base_reg, lo_next};
                  s1_be_reg <= be_in;
                  s1_drv_reg <= 1'b0;
               end
               ST_IDLE: begin
                  s1_op_reg <= `PZT_OP_NONE;
                  s1_drv_reg <= 1'b0;
               end
               default: begin
                  state_reg <= ST_IDLE;
                  s1_op_reg <= `PZT_OP_NONE;
                  s1_drv_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // second stage: commands already issued drain even after a deselect
   always @(posedge core_clk) begin
      if (srst) begin
         s2_op_reg <= `PZT_OP_NONE;
         s2_addr_reg <= {ADDR_W{1'b0}};
         s2_be_reg <= {LANES{1'b0}};
         s2_drv_reg <= 1'b0;
      end else if (sleep_active) begin
         // sleep flushes the pipe; words already buffered survive
         s2_op_reg <= `PZT_OP_NONE;
         s2_drv_reg <= 1'b0;
      end else if (!stall) begin
         s2_op_reg <= s1_op_reg;
         s2_addr_reg <= s1_addr_reg;
         s2_be_reg <= s1_be_reg;
         s2_drv_reg <= s1_drv_reg;
      end
   end

   // output stage
   always @(posedge core_clk) begin
      if (srst) begin
         dq_out <= {DATA_W{1'b0}};
         dq_oe <= 1'b0;
      end else if (sleep_active) begin
         dq_oe <= 1'b0;
      end else if (stall) begin
         // held read keeps driving; output enable still turns it off
         dq_oe <= dq_oe & ~output_drive_enable_n;
      end else if (s2_op_reg == `PZT_OP_READ) begin
         // a dummy read or a raised output enable keeps the bus released
         dq_out <= fwd_word;
         dq_oe <= s2_drv_reg & ~output_drive_enable_n;
      end else begin
         // writes, aborts and deselects leave the bus released
         dq_oe <= 1'b0;
      end
   end

endmodule // pzt_sram_port

// >>> verilog/pzt_sram_regs.vh
`ifndef PZT_SRAM_REGS_VH
`define PZT_SRAM_REGS_VH

// array geometry
`define PZT_ADDR_W 21
`define PZT_DATA_W 18
`define PZT_LANE_W 9
`define PZT_LANES 2

// pipeline latencies, in core_clk cycles
`define PZT_RD_LAT 2
`define PZT_WR_LAT 2
`define PZT_DESEL_LAT 2

// sleep timing, in core_clk cycles
`define PZT_SLEEP_ENTRY_CYC 2
`define PZT_WAKE_SETTLE_CYC 2
`define PZT_SLEEP_CURRENT_DLY 2

// pipeline opcodes
`define PZT_OP_NONE 2'h0
`define PZT_OP_READ 2'h1
`define PZT_OP_WRITE 2'h2

// posted-write buffer
`define PZT_BUF_DEPTH 2

`endif

// >>> tb/pzt_sram_port_sva.sv
module pzt_sram_port_sva (
   // clock and reset
   input logic core_clk,
   input logic srst,
   // command
   input logic select_low_a,
   input logic select_high,
   input logic select_low_b,
   input logic advance_or_load,
   input logic read_not_write,
   input logic clock_hold_n,
   input logic output_drive_enable_n,
   input logic sleep_request,
   // outputs
   input logic [17:0] dq_out,
   input logic dq_oe,
   input logic sleep_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire sel = !select_low_a && select_high && !select_low_b;
   wire run = !clock_hold_n && !sleep_request && !sleep_active;
   wire load = run && !advance_or_load;
   sequence rd_cmd;
      load && sel && read_not_write;
   endsequence
   sequence drain2;
      (run && !output_drive_enable_n) [*2];
   endsequence
   a_read_lat: assert property (rd_cmd ##0 !output_drive_enable_n ##1 drain2 |=> dq_oe)
      else $error("read not driven");
   a_write_quiet: assert property (load && sel && !read_not_write ##1 drain2 |=> !dq_oe)
      else $error("driven on write");
   a_desel_drain: assert property (load && !sel ##1 !clock_hold_n [*2] |=> !dq_oe)
      else $error("driven after deselect");
   a_dummy_read: assert property (rd_cmd ##0 output_drive_enable_n ##1 !clock_hold_n [*2] |=> !dq_oe)
      else $error("dummy read drove");
   a_hold_data: assert property (clock_hold_n && !sleep_request && !sleep_active |=> $stable(dq_out))
      else $error("data moved on held edge");
   a_sleep_flag: assert property (1 |=> sleep_active == $past(sleep_request))
      else $error("sleep flag wrong");
   a_sleep_quiet: assert property (sleep_active |=> !dq_oe)
      else $error("driven while asleep");
   a_oe_gate: assert property (output_drive_enable_n |=> !dq_oe)
      else $error("driven with output enable off");
endmodule // pzt_sram_port_sva

bind pzt_sram_port pzt_sram_port_sva u_sva (.core_clk(core_clk), .srst(srst),
   .select_low_a(select_low_a), .select_high(select_high), .select_low_b(select_low_b),
   .advance_or_load(advance_or_load), .read_not_write(read_not_write),
   .clock_hold_n(clock_hold_n), .output_drive_enable_n(output_drive_enable_n),
   .sleep_request(sleep_request), .dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active));

// >>> tb/pzt_master_model.sv
module pzt_master_model (
   // clock and stall
   input logic core_clk,
   input logic clock_hold_n,
   // write slot request
   input logic wr_slot,
   input logic [17:0] wdata,
   // data toward the device
   output logic [17:0] dq_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [18:0] s1 = 19'h00000;
   logic [18:0] s2 = 19'h00000;
   always @(posedge core_clk) begin
      if (!clock_hold_n) begin
         s1 <= {wr_slot, wdata};
         s2 <= s1;
      end
   end
   // outside a data slot the bus shows junk, not the last word
   assign dq_in = s2[18] ? s2[17:0] : ~s2[17:0];
endmodule // pzt_master_model

// >>> tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] ON = 3'b010;
   localparam logic [2:0] OFF = 3'b101;
   logic [17:0] A [4] = '{18'h10001, 18'h20a02, 18'h0b503, 18'h3c004};
   logic core_clk = 1'b0, srst = 1'b1, select_low_a = 1'b1, select_high = 1'b1;
   logic select_low_b = 1'b0, advance_or_load = 1'b0, read_not_write = 1'b1;
   logic clock_hold_n = 1'b0, burst_order_select = 1'b1, output_drive_enable_n = 1'b0;
   logic sleep_request = 1'b0, dq_oe, sleep_active, wr_slot = 1'b0, act = 1'b0, wr_m = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [1:0] byte_lane_write_n = 2'b00;
   logic [17:0] dq_in, dq_out, wdata = 18'h00000;
   logic [1:0] pc [2] = '{2'h0, 2'h0};
   logic [17:0] pv [2] = '{18'h00000, 18'h00000};
   int err_total = 0, total_checks = 0, cyc = 0;

   always #12.5 core_clk = ~core_clk;

   pzt_sram_port #(.ADDR_W(8), .DEPTH(256)) DUT (.core_clk(core_clk), .srst(srst),
      .addr(addr), .select_low_a(select_low_a), .select_high(select_high),
      .select_low_b(select_low_b), .advance_or_load(advance_or_load),
      .read_not_write(read_not_write), .byte_lane_write_n(byte_lane_write_n),
      .clock_hold_n(clock_hold_n), .output_drive_enable_n(output_drive_enable_n),
      .burst_order_select(burst_order_select), .sleep_request(sleep_request),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active));
   pzt_master_model u_master (.core_clk(core_clk), .clock_hold_n(clock_hold_n),
      .wr_slot(wr_slot), .wdata(wdata), .dq_in(dq_in));

   task cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one bus cycle; results are judged two taken edges later
   task step(input logic [2:0] s, input logic ld, rnw, input logic [7:0] a,
             input logic [1:0] be, input logic [17:0] v, input logic [1:0] chk);
      {select_low_a, select_high, select_low_b} = s;
      advance_or_load = !ld;
      read_not_write = rnw;
      addr = a;
      byte_lane_write_n = be;
      wdata = v;
      if (ld) begin
         act = (s == ON);
         wr_m = !rnw;
      end
      wr_slot = act && wr_m && !sleep_request;
      @(negedge core_clk);
      if (pc[1] == 2'h1) cmp("dq_out", pv[1], dq_out);
      if (pc[1] != 2'h0) cmp("dq_oe", {17'h0, pc[1] == 2'h1}, {17'h0, dq_oe});
      pc[1] = pc[0];
      pv[1] = pv[0];
      pc[0] = chk;
      pv[0] = v;
   endtask

   task flush;
      step(3'b110, 1, 1, 8'h00, 2'b00, 18'h00000, 2);
      step(3'b000, 1, 1, 8'h00, 2'b00, 18'h00000, 2);
   endtask

   task t_burst;
      step(ON, 1, 0, 8'h25, 2'b00, A[0], 2);
      step(OFF, 0, 1, 8'hff, 2'b00, A[1], 2);
      step(OFF, 0, 1, 8'hff, 2'b00, A[2], 2);
      step(OFF, 0, 1, 8'hff, 2'b00, A[3], 2);
      step(ON, 1, 1, 8'h27, 2'b11, A[2], 1);
      step(OFF, 0, 0, 8'h00, 2'b11, A[3], 1);
      step(OFF, 0, 0, 8'h00, 2'b11, A[0], 1);
      step(OFF, 0, 0, 8'h00, 2'b11, A[1], 1);
      step(3'b011, 1, 1, 8'h00, 2'b00, 18'h00000, 2);
      step(ON, 0, 1, 8'h25, 2'b00, 18'h00000, 2);
      flush();
   endtask

   task t_linear;
      burst_order_select = 1'b0;
      step(ON, 1, 1, 8'h26, 2'b00, A[3], 1);
      step(OFF, 0, 1, 8'h00, 2'b00, A[2], 1);
      clock_hold_n = 1'b1;
      @(negedge core_clk);
      clock_hold_n = 1'b0;
      step(OFF, 0, 1, 8'h00, 2'b00, A[1], 1);
      step(OFF, 0, 1, 8'h00, 2'b00, A[0], 1);
      step(ON, 1, 0, 8'h25, 2'b10, 18'h3ffff, 2);
      step(ON, 1, 0, 8'h24, 2'b11, 18'h3ffff, 2);
      step(ON, 1, 1, 8'h25, 2'b00, 18'h101ff, 1);
      step(ON, 1, 1, 8'h24, 2'b00, A[1], 1);
      flush();
   endtask

   task t_dummy;
      step(ON, 1, 1, 8'h24, 2'b00, 18'h00000, 2);
      output_drive_enable_n = 1'b1;
      step(ON, 1, 1, 8'h24, 2'b00, 18'h00000, 2);
      step(OFF, 0, 1, 8'h00, 2'b00, 18'h00000, 2);
      flush();
      output_drive_enable_n = 1'b0;
   endtask

   task t_sleep;
      sleep_request = 1'b1;
      step(3'b110, 1, 1, 8'h00, 2'b00, 18'h00000, 0);
      repeat (2) step(ON, 1, 0, 8'h25, 2'b00, 18'h2aaaa, 0);
      cmp("sleep_active", 18'h00001, {17'h0, sleep_active});
      sleep_request = 1'b0;
      flush();
      step(ON, 1, 1, 8'h25, 2'b00, 18'h101ff, 1);
      flush();
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // the whole run needs well under a hundred cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      @(negedge core_clk);
      t_burst();
      t_linear();
      t_dummy();
      t_sleep();
      end_of_test();
   end
endmodule // tb
